// ==== opsq_top.sv ====
// Output driver power sequencer: page-1 registers, drivers, converter order.
// Assumes a byte register port synchronous to clk and a live short input.
module opsq_top
    import opsq_pkg::*;
#(
    parameter int unsigned OSC_KHZ = OSC_KHZ_NOM
)(
    input wire logic clk,
    input wire logic reset_n,
    input wire logic clk_en,
    input wire logic osc_tick,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    output logic [7:0] reg_rdata_q,
    input wire logic spk_short,
    input wire logic spk_err_keep,
    input wire logic left_headphone_en,
    input wire logic right_headphone_en,
    input wire logic sw_power_down,
    input wire logic [NDRV-1:0][GAIN_W-1:0] gain_target,
    output logic [NDRV-1:0] drv_power_q,
    output logic [NDRV-1:0][GAIN_W-1:0] drv_gain_q,
    output logic [NDRV-1:0] gain_done_q,
    output logic dac_power_down_q,
    output logic vcm_bandgap_q
);
    logic [7:0] page_q;
    logic [7:0] page_d;
    logic [7:0] spk_q;
    logic [7:0] spk_d;
    logic [7:0] pop_q;
    logic [7:0] pop_d;
    logic [7:0] ramp_q;
    logic [7:0] ramp_d;
    logic [7:0] rdata_d;
    logic page_ok;
    logic [NDRV-1:0] drv_en;
    logic [NDRV-1:0] pw;
    logic [NDRV-1:0] dn;
    logic [NDRV-1:0][GAIN_W-1:0] gn;
    logic dac_pd_d;
    logic [CNT_W-1:0] pon_cnt;
    logic [CNT_W-1:0] step_cnt;
    logic [CNT_W-1:0] wait_cnt;

    // only page 1 reaches this block
    assign page_ok = (page_q == PAGE_SEL);

    // Register writes; the page register sits at offset 0 of every page
    always_comb
    begin
        page_d = page_q;
        spk_d = spk_q;
        pop_d = pop_q;
        ramp_d = ramp_q;
        if (reg_wr)
        begin
            if (reg_addr == ADDR_PAGE)
                page_d = reg_wdata;
            // left and right power bits stored
            else if (page_ok && reg_addr == ADDR_SPK)
                spk_d = {reg_wdata[7:1], 1'b0};
            else if (page_ok && reg_addr == ADDR_POP)
                pop_d = reg_wdata;
            else if (page_ok && reg_addr == ADDR_RAMP)
                ramp_d = reg_wdata;
        end
        // Protection wins over a same-cycle write that sets the bits
        // short clears speaker power
        if (spk_short && !spk_err_keep)
        begin
            spk_d[SPK_L_BIT] = 1'b0;
            spk_d[SPK_R_BIT] = 1'b0;
        end
    end

    // Readback; unmapped offsets and other pages read zero, apart from the page register at offset 0
    // live short bit in D0
    always_comb
    begin
        rdata_d = '0;
        if (reg_addr == ADDR_PAGE)
            rdata_d = page_q;
        else if (page_ok && reg_addr == ADDR_SPK)
            rdata_d = {spk_q[7:1], spk_short};
        else if (page_ok && reg_addr == ADDR_POP)
            rdata_d = pop_q;
        else if (page_ok && reg_addr == ADDR_RAMP)
            rdata_d = ramp_q;
    end

    // Driver enables; software power-down takes every amplifier down
    // speaker bits drive speaker sequencers
    always_comb
    begin
        drv_en[0] = spk_q[SPK_L_BIT];
        drv_en[1] = spk_q[SPK_R_BIT];
        drv_en[2] = left_headphone_en;
        drv_en[3] = right_headphone_en;
        if (sw_power_down)
            drv_en = '0;
    end

    // Converter order chosen by the pop-removal order bit
    // together with amps at order bit 0, after all drivers idle at order bit 1
    always_comb
    begin
        dac_pd_d = 1'b0;
        if (sw_power_down)
            dac_pd_d = !pop_q[ORDER_BIT] || (pw == '0);
    end

    // Register state and registered outputs
    always_ff @(posedge clk)
    begin
        if (!reset_n)
        begin
            page_q <= PAGE_RST;
            spk_q <= SPK_RST;
            pop_q <= POP_RST;
            ramp_q <= RAMP_RST;
            reg_rdata_q <= '0;
            drv_power_q <= '0;
            drv_gain_q <= '0;
            gain_done_q <= '0;
            dac_power_down_q <= 1'b0;
            vcm_bandgap_q <= 1'b0;
        end
        else if (clk_en)
        begin
            page_q <= page_d;
            spk_q <= spk_d;
            pop_q <= pop_d;
            ramp_q <= ramp_d;
            reg_rdata_q <= rdata_d;
            drv_power_q <= pw;
            drv_gain_q <= gn;
            gain_done_q <= dn;
            dac_power_down_q <= dac_pd_d;
            vcm_bandgap_q <= pop_q[VCM_BIT];
        end
    end

    // One shared code-to-count table for all drivers
    // wait counted on oscillator ticks
    opsq_dur #(.OSC_KHZ(OSC_KHZ)) u_dur (
        .clk(clk),
        .reset_n(reset_n),
        .clk_en(clk_en),
        .pon_code(pop_q[PON_LSB +: PON_W]),
        .step_code(pop_q[STEP_LSB +: STEP_W]),
        .wait_code(ramp_q[WAIT_LSB +: WAIT_W]),
        .pon_cnt_q(pon_cnt),
        .step_cnt_q(step_cnt),
        .wait_cnt_q(wait_cnt)
    );

    opsq_seq_if seq [NDRV] ();

    // Speakers get the extra wait, headphones skip it
    for (genvar g = 0; g < NDRV; g++)
    begin : g_drv
        assign seq[g].en = drv_en[g];
        assign seq[g].osc_tick = osc_tick;
        assign seq[g].target = gain_target[g];
        assign seq[g].wait_cnt = (g < NSPK) ? wait_cnt : '0;
        assign seq[g].pon_cnt = pon_cnt;
        assign seq[g].step_cnt = step_cnt;
        assign pw[g] = seq[g].powered;
        assign dn[g] = seq[g].done;
        assign gn[g] = seq[g].gain;
        opsq_drv u_drv (
            .clk(clk),
            .reset_n(reset_n),
            .clk_en(clk_en),
            .sq(seq[g])
        );
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);

    sequence s_two_en;
        clk_en ##1 clk_en;
    endsequence

    a_page_gate: assert property (reg_wr && clk_en && !page_ok &&
        reg_addr == ADDR_POP |=> pop_q == $past(pop_q))
        else $error("write reached block off page 1");
    a_left_off: assert property (!spk_q[SPK_L_BIT] ##0 s_two_en
        |=> !drv_power_q[0]) else $error("left speaker not held off");
    a_right_on: assert property (spk_q[SPK_R_BIT] && !sw_power_down
        ##0 s_two_en |=> drv_power_q[1])
        else $error("right speaker not powered");
    a_short_live: assert property (clk_en && page_ok &&
        reg_addr == ADDR_SPK |=> reg_rdata_q[SPK_SC_BIT] == $past(spk_short))
        else $error("short bit not live");
    a_short_clear: assert property (clk_en && spk_short &&
        !spk_err_keep |=> spk_q[SPK_L_BIT:SPK_R_BIT] == '0)
        else $error("short did not clear speaker bits");
    a_dac_with: assert property (clk_en && sw_power_down &&
        !pop_q[ORDER_BIT] |=> dac_power_down_q)
        else $error("converter not down with amps");
    a_dac_after: assert property (clk_en && sw_power_down &&
        pop_q[ORDER_BIT] && pw != '0 |=> !dac_power_down_q)
        else $error("converter down before amps");
    a_vcm_sel: assert property (clk_en |=>
        vcm_bandgap_q == $past(pop_q[VCM_BIT]))
        else $error("common-mode source wrong");
endmodule : opsq_top

// ==== opsq_pkg.sv ====
// Constants, tables and helpers for the output driver power sequencer.
// Assumes one 125 MHz clock and an oscillator tick pulse at about 8.2 MHz.
package opsq_pkg;
    localparam logic [7:0] ADDR_PAGE = 8'h00;
    localparam logic [7:0] ADDR_SPK = 8'h20;
    localparam logic [7:0] ADDR_POP = 8'h21;
    localparam logic [7:0] ADDR_RAMP = 8'h22;
    localparam logic [7:0] PAGE_SEL = 8'h01;
    localparam logic [7:0] PAGE_RST = 8'h00;
    localparam logic [7:0] SPK_RST = 8'h06;
    localparam logic [7:0] POP_RST = 8'h3e;
    localparam logic [7:0] RAMP_RST = 8'h00;
    localparam int SPK_L_BIT = 7;
    localparam int SPK_R_BIT = 6;
    localparam int SPK_SC_BIT = 0;
    localparam int ORDER_BIT = 7;
    localparam int VCM_BIT = 0;
    localparam int PON_LSB = 3;
    localparam int STEP_LSB = 1;
    localparam int WAIT_LSB = 4;
    localparam int PON_W = 4;
    localparam int STEP_W = 2;
    localparam int WAIT_W = 3;
    localparam logic [PON_W-1:0] PON_MAX = 4'hb;
    localparam int CNT_W = 26;
    localparam int GAIN_W = 7;
    localparam int NDRV = 4;
    localparam int NSPK = 2;
    localparam int unsigned OSC_KHZ_NOM = 8200;
    localparam longint NS_KHZ_DIV = 1000000;
    // Durations in ns, as printed for the nominal oscillator
    localparam longint PON_NS [12] = '{0, 15300, 15300, 1530000, 15300000,
        76200000, 153000000, 304000000, 610000000, 1220000000, 64'd3040000000,
        64'd6100000000};
    localparam longint STEP_NS [4] = '{0, 980000, 1950000, 3900000};
    localparam longint WAIT_NS [8] = '{0, 3040000, 7620000, 12200000,
        15300000, 19800000, 24400000, 30500000};

    // Oscillator cycles in a duration, rounded down
    function automatic logic [CNT_W-1:0] osc_cycles(input longint ns,
        input int unsigned khz);
        longint c;
        c = ns * longint'(khz) / NS_KHZ_DIV;
        return c[CNT_W-1:0];
    endfunction : osc_cycles

    typedef enum logic [2:0] {
        ST_IDLE = 3'h0,
        ST_WAIT = 3'h1,
        ST_PON = 3'h3,
        ST_RAMP = 3'h2,
        ST_ON = 3'h6
    } opsq_state_t;
endpackage : opsq_pkg

// ==== opsq_seq_if.sv ====
// Link between the register logic and one driver sequencer.
// Assumes the controller drives all timing counts from one shared table.
interface opsq_seq_if;
    import opsq_pkg::*;
    logic en;
    logic osc_tick;
    logic [GAIN_W-1:0] target;
    logic [CNT_W-1:0] wait_cnt;
    logic [CNT_W-1:0] pon_cnt;
    logic [CNT_W-1:0] step_cnt;
    logic powered;
    logic done;
    logic [GAIN_W-1:0] gain;
    modport ctl (output en, osc_tick, target, wait_cnt, pon_cnt, step_cnt,
        input powered, done, gain);
    modport drv (input en, osc_tick, target, wait_cnt, pon_cnt, step_cnt,
        output powered, done, gain);
endinterface : opsq_seq_if

// ==== opsq_dur.sv ====
// Converts the programmed time codes into oscillator cycle counts.
// Assumes codes are stable register fields; results lag them by one clock.
module opsq_dur
    import opsq_pkg::*;
#(
    parameter int unsigned OSC_KHZ = OSC_KHZ_NOM
)(
    input wire logic clk,
    input wire logic reset_n,
    input wire logic clk_en,
    input wire logic [PON_W-1:0] pon_code,
    input wire logic [STEP_W-1:0] step_code,
    input wire logic [WAIT_W-1:0] wait_code,
    output logic [CNT_W-1:0] pon_cnt_q,
    output logic [CNT_W-1:0] step_cnt_q,
    output logic [CNT_W-1:0] wait_cnt_q
);
    logic [CNT_W-1:0] pon_cnt_d;
    logic [CNT_W-1:0] step_cnt_d;
    logic [CNT_W-1:0] wait_cnt_d;
    logic [PON_W-1:0] pon_idx;

    // Reserved power-on codes fall back to the longest time, the safe side
    // power-on table
    always_comb
    begin
        pon_idx = (pon_code > PON_MAX) ? PON_MAX : pon_code;
        pon_cnt_d = osc_cycles(PON_NS[pon_idx], OSC_KHZ);
        step_cnt_d = osc_cycles(STEP_NS[step_code], OSC_KHZ);
        wait_cnt_d = osc_cycles(WAIT_NS[wait_code], OSC_KHZ);
    end

    // Count registers
    always_ff @(posedge clk)
    begin
        if (!reset_n)
        begin
            pon_cnt_q <= osc_cycles(PON_NS[POP_RST[PON_LSB +: PON_W]],
                OSC_KHZ);
            step_cnt_q <= osc_cycles(STEP_NS[POP_RST[STEP_LSB +: STEP_W]],
                OSC_KHZ);
            wait_cnt_q <= osc_cycles(WAIT_NS[RAMP_RST[WAIT_LSB +: WAIT_W]],
                OSC_KHZ);
        end
        else if (clk_en)
        begin
            pon_cnt_q <= pon_cnt_d;
            step_cnt_q <= step_cnt_d;
            wait_cnt_q <= wait_cnt_d;
        end
    end

    // slowest step code gives the 3.9 ms count
    a_step_table: assert property (@(posedge clk) disable iff (!reset_n)
        clk_en && step_code == POP_RST[STEP_LSB +: STEP_W] |=>
        step_cnt_q == osc_cycles(STEP_NS[POP_RST[STEP_LSB +: STEP_W]],
        OSC_KHZ)) else $error("step count table wrong");
endmodule : opsq_dur

// ==== opsq_drv.sv ====
// Power-up sequencer for one output driver: wait, power-on, gain ramp.
// Assumes the counts and target are held stable while the driver runs.
module opsq_drv
    import opsq_pkg::*;
(
    input wire logic clk,
    input wire logic reset_n,
    input wire logic clk_en,
    opsq_seq_if.drv sq
);
    opsq_state_t state_q;
    opsq_state_t state_d;
    logic [CNT_W-1:0] cnt_q;
    logic [CNT_W-1:0] cnt_d;
    logic [GAIN_W-1:0] gain_q;
    logic [GAIN_W-1:0] gain_d;

    // Next state; a dropped enable powers down at once, gain back to zero
    // wait, then power-on time, then ramp
    always_comb
    begin
        state_d = state_q;
        cnt_d = cnt_q;
        gain_d = gain_q;
        case (state_q)
            ST_IDLE:
            begin
                gain_d = '0;
                if (sq.en)
                begin
                    state_d = ST_WAIT;
                    cnt_d = sq.wait_cnt;
                end
            end
            ST_WAIT:
            begin
                if (cnt_q == '0)
                begin
                    state_d = ST_PON;
                    cnt_d = sq.pon_cnt;
                end
                else if (sq.osc_tick)
                    cnt_d = cnt_q - 1'b1;
            end
            ST_PON:
            begin
                if (cnt_q == '0)
                begin
                    state_d = ST_RAMP;
                    cnt_d = sq.step_cnt;
                end
                else if (sq.osc_tick)
                    cnt_d = cnt_q - 1'b1;
            end
            // one gain step per step time
            ST_RAMP:
            begin
                if (gain_q >= sq.target)
                    state_d = ST_ON;
                else if (cnt_q == '0)
                begin
                    gain_d = gain_q + 1'b1;
                    cnt_d = sq.step_cnt;
                end
                else if (sq.osc_tick)
                    cnt_d = cnt_q - 1'b1;
            end
            ST_ON:
            begin
                if (gain_q < sq.target)
                begin
                    state_d = ST_RAMP;
                    cnt_d = sq.step_cnt;
                end
            end
            default: state_d = ST_IDLE;
        endcase
        if (!sq.en)
        begin
            state_d = ST_IDLE;
            gain_d = '0;
        end
    end

    // State registers
    always_ff @(posedge clk)
    begin
        if (!reset_n)
        begin
            state_q <= ST_IDLE;
            cnt_q <= '0;
            gain_q <= '0;
        end
        else if (clk_en)
        begin
            state_q <= state_d;
            cnt_q <= cnt_d;
            gain_q <= gain_d;
        end
    end

    assign sq.powered = (state_q != ST_IDLE);
    assign sq.done = (state_q == ST_ON);
    assign sq.gain = gain_q;

    // power-on ends only when its count is spent
    a_pon_end: assert property (@(posedge clk) disable iff (!reset_n)
        state_q == ST_PON && state_d == ST_RAMP |-> cnt_q == '0)
        else $error("power-on ended early");
    // the wait count steps down only on oscillator ticks
    a_tick_only: assert property (@(posedge clk) disable iff (!reset_n)
        state_q == ST_WAIT && sq.en && clk_en && !sq.osc_tick &&
        cnt_q != '0 |=> cnt_q == $past(cnt_q))
        else $error("timer moved without tick");
    // gain climbs one step at a time
    a_ramp_step: assert property (@(posedge clk) disable iff (!reset_n)
        $changed(gain_q) |-> gain_q == '0 || gain_q == $past(gain_q) + 1'b1)
        else $error("gain jumped");
endmodule : opsq_drv

// ==== opsq_top_bench.sv ====
// Self-checking bench for the output driver power sequencer top.
// Assumes a slow oscillator setting (OSC_KHZ=1) so counts equal ns/1e6.
module opsq_top_bench;
    import opsq_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;

    typedef struct packed {
        logic [7:0] a;
        logic [7:0] w;
        logic [7:0] e;
        logic [1:0] p;
        logic v;
    } opsq_row_t;

    logic clk = 1'b0;
    logic reset_n = 1'b0;
    logic clk_en = 1'b1;
    logic osc_tick = 1'b0;
    logic [7:0] reg_addr = 8'h00;
    logic [7:0] reg_wdata = 8'h00;
    logic reg_wr = 1'b0;
    logic [7:0] reg_rdata_q;
    logic spk_short = 1'b0;
    logic spk_err_keep = 1'b0;
    logic left_headphone_en = 1'b0;
    logic right_headphone_en = 1'b0;
    logic sw_power_down = 1'b0;
    logic [NDRV-1:0][GAIN_W-1:0] gain_target = '0;
    logic [NDRV-1:0] drv_power_q;
    logic [NDRV-1:0][GAIN_W-1:0] drv_gain_q;
    logic [NDRV-1:0] gain_done_q;
    logic dac_power_down_q;
    logic vcm_bandgap_q;
    int errors = 0;
    int total_checks = 0;
    int cycles = 0;
    opsq_row_t rows [8] = '{
        '{8'h20, 8'h86, 8'h86, 2'h1, 1'b0},
        '{8'h20, 8'h47, 8'h46, 2'h2, 1'b0},
        '{8'h20, 8'h06, 8'h06, 2'h0, 1'b0},
        '{8'h21, 8'h81, 8'h81, 2'h0, 1'b1},
        '{8'h21, 8'h3e, 8'h3e, 2'h0, 1'b0},
        '{8'h22, 8'h70, 8'h70, 2'h0, 1'b0},
        '{8'h22, 8'h00, 8'h00, 2'h0, 1'b0},
        '{8'h05, 8'h55, 8'h00, 2'h0, 1'b0}};

    // Slow timing so the longest codes still fit a short run
    opsq_top #(
        .OSC_KHZ(1)
    ) i_opsq_top (
        .clk(clk),
        .reset_n(reset_n),
        .clk_en(clk_en),
        .osc_tick(osc_tick),
        .reg_addr(reg_addr),
        .reg_wdata(reg_wdata),
        .reg_wr(reg_wr),
        .reg_rdata_q(reg_rdata_q),
        .spk_short(spk_short),
        .spk_err_keep(spk_err_keep),
        .left_headphone_en(left_headphone_en),
        .right_headphone_en(right_headphone_en),
        .sw_power_down(sw_power_down),
        .gain_target(gain_target),
        .drv_power_q(drv_power_q),
        .drv_gain_q(drv_gain_q),
        .gain_done_q(gain_done_q),
        .dac_power_down_q(dac_power_down_q),
        .vcm_bandgap_q(vcm_bandgap_q)
    );

    // 125 MHz clock
    always #4 clk = ~clk;

    // Oscillator tick every other cycle, so one tick is two clocks
    always @(posedge clk)
    begin
        osc_tick <= ~osc_tick;
    end

    // Cycle ceiling cuts a hung run short
    always @(posedge clk)
    begin
        cycles <= cycles + 1;
        if (cycles == 20000)
        begin
            errors++;
            results();
        end
    end

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        total_checks++;
        if (got !== exp)
        begin
            errors++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    // One write strobe; the next call waits a fresh edge
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        @(posedge clk);
        reg_addr <= a;
        repeat (2) @(posedge clk);
        #1;
        chk(reg_rdata_q, exp);
    endtask : rd

    task automatic step(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : step

    // Bounded wait for one driver to finish its ramp
    task automatic wait_done(input int i, input int n);
        int k;
        for (k = 0; k < n; k++)
        begin
            @(posedge clk);
            #1;
            if (gain_done_q[i] === 1'b1)
                break;
        end
        chk({7'h00, gain_done_q[i]}, 8'h01);
    endtask : wait_done

    task automatic results();
        $display("Checks %0d, mismatches %0d", total_checks, errors);
        if (errors == 0 && total_checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : results

    initial
    begin
        repeat (2) @(posedge clk);
        reset_n <= 1'b1;
        #1;
        chk({4'h0, drv_power_q}, 8'h00);
        chk({7'h00, vcm_bandgap_q}, 8'h00);
        rd(8'h00, 8'h00);
        rd(8'h20, 8'h00);
        wr(8'h21, 8'h81);
        wr(8'h00, 8'h01);
        rd(8'h20, 8'h06);
        rd(8'h21, 8'h3e);
        rd(8'h22, 8'h00);
        // Ordinary register rows: write, read back, watch outputs
        foreach (rows[i])
        begin
            wr(rows[i].a, rows[i].w);
            rd(rows[i].a, rows[i].e);
            chk({6'h00, drv_power_q[1:0]}, {6'h00, rows[i].p});
            chk({7'h00, vcm_bandgap_q}, {7'h00, rows[i].v});
        end
        // Live short bit, kept and then cleared speaker bits
        spk_short <= 1'b1;
        spk_err_keep <= 1'b1;
        wr(8'h20, 8'hc6);
        rd(8'h20, 8'hc7);
        chk({6'h00, drv_power_q[1:0]}, 8'h03);
        spk_err_keep <= 1'b0;
        step(3);
        rd(8'h20, 8'h07);
        step(3);
        chk({6'h00, drv_power_q[1:0]}, 8'h00);
        spk_short <= 1'b0;
        rd(8'h20, 8'h06);
        // Speaker waits 30 ticks; headphone skips that wait
        gain_target[0] <= 7'h05;
        gain_target[2] <= 7'h05;
        wr(8'h22, 8'h70);
        wr(8'h21, 8'h18);
        wr(8'h20, 8'h86);
        left_headphone_en <= 1'b1;
        step(40);
        chk({7'h00, gain_done_q[2]}, 8'h01);
        chk({1'b0, drv_gain_q[0]}, 8'h00);
        wait_done(0, 200);
        chk({1'b0, drv_gain_q[0]}, 8'h05);
        wr(8'h20, 8'h06);
        left_headphone_en <= 1'b0;
        // Power-on code 0111 holds gain at zero for 304 ticks
        gain_target[1] <= 7'h02;
        wr(8'h22, 8'h00);
        wr(8'h21, 8'h38);
        wr(8'h20, 8'h46);
        step(550);
        chk({1'b0, drv_gain_q[1]}, 8'h00);
        chk({7'h00, drv_power_q[1]}, 8'h01);
        wait_done(1, 300);
        // Step code 11 spaces ramp steps by three ticks
        gain_target[3] <= 7'h03;
        wr(8'h21, 8'h06);
        right_headphone_en <= 1'b1;
        step(10);
        chk({7'h00, gain_done_q[3]}, 8'h00);
        wait_done(3, 60);
        // Order bit 0: converter drops with the amplifiers
        wr(8'h21, 8'h00);
        @(posedge clk);
        sw_power_down <= 1'b1;
        step(1);
        chk({7'h00, dac_power_down_q}, 8'h01);
        sw_power_down <= 1'b0;
        step(8);
        // Order bit 1: converter drops only after all drivers idle
        wr(8'h21, 8'h80);
        @(posedge clk);
        sw_power_down <= 1'b1;
        step(1);
        chk({7'h00, dac_power_down_q}, 8'h00);
        for (int k = 0; k < 10 && dac_power_down_q !== 1'b1; k++)
            step(1);
        chk({7'h00, dac_power_down_q}, 8'h01);
        chk({4'h0, drv_power_q}, 8'h00);
        sw_power_down <= 1'b0;
        // Writes are ignored while the clock enable is low
        clk_en <= 1'b0;
        wr(8'h21, 8'h3e);
        clk_en <= 1'b1;
        rd(8'h21, 8'h80);
        // Mid-run reset with the clock enable low still clears state
        right_headphone_en <= 1'b0;
        clk_en <= 1'b0;
        reset_n <= 1'b0;
        step(2);
        chk({4'h0, drv_power_q}, 8'h00);
        reset_n <= 1'b1;
        clk_en <= 1'b1;
        rd(8'h00, 8'h00);
        wr(8'h00, 8'h01);
        rd(8'h21, 8'h3e);
        results();
    end
endmodule : opsq_top_bench
